// ==== pcl_pkg.sv ====
package pcl_pkg;

  // ==========================================================
  // address formation
  localparam logic [23:0] IP_PREFIX  = 24'hc0_a801;
  localparam logic [31:0] DEFAULT_IP = 32'hc0a8_01fa;
  localparam logic [7:0]  NA_MIN     = 8'h01;
  localparam logic [7:0]  NA_MAX     = 8'hfe;

  // ==========================================================
  // non-volatile store layout
  localparam logic        NV_IP_IDX   = 1'b0;
  localparam logic        NV_FLAG_IDX = 1'b1;
  localparam logic [31:0] NV_MAGIC    = 32'h5a5a_a5a5;
  localparam logic [31:0] NV_CLEARED  = 32'h0000_0000;

  // ==========================================================
  // register byte offsets
  localparam logic [7:0] OFS_STATUS  = 8'h00;
  localparam logic [7:0] OFS_ACT_IP  = 8'h04;
  localparam logic [7:0] OFS_PEND_IP = 8'h08;
  localparam logic [7:0] OFS_OUT     = 8'h0c;
  localparam logic [7:0] OFS_IRQ_ST  = 8'h10;
  localparam logic [7:0] OFS_IRQ_CLR = 8'h14;
  localparam logic [7:0] OFS_IRQ_EN  = 8'h18;
  localparam logic [7:0] OFS_PATH    = 8'h1c;

  // ==========================================================
  // status register fields
  localparam int ST_SW_MODE = 0;
  localparam int ST_HOLD    = 1;
  localparam int ST_CFG_ERR = 2;
  localparam int ST_LOADED  = 3;
  localparam int ST_JOINED  = 4;
  localparam int ST_NA_LSB  = 8;

  // ==========================================================
  // interrupt bits
  localparam int IRQ_W       = 4;
  localparam int IRQ_COMM    = 0;
  localparam int IRQ_CFG_ERR = 1;
  localparam int IRQ_LOADED  = 2;
  localparam int IRQ_IP_WR   = 3;

  // ==========================================================
  // object path of the written ip configuration
  localparam logic [7:0] TCPIP_CLASS = 8'hf5;
  localparam logic [7:0] TCPIP_INST  = 8'h01;
  localparam logic [7:0] TCPIP_ATTR  = 8'h05;

  // ==========================================================
  // bus answers
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [2:0] {
    PCL_SAMPLE,
    PCL_RD_IP,
    PCL_RD_FLAG,
    PCL_WR_IP,
    PCL_WR_FLAG,
    PCL_RUN,
    PCL_SW_IP,
    PCL_SW_FLAG
  } pcl_state_t;

endpackage

// ==== pcl_nv_if.sv ====
`timescale 1ns/10ps
interface pcl_nv_if;
  logic        we;
  logic        addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  modport ctrl (output we, output addr, output wdata, input rdata);
  modport mem  (input we, input addr, input wdata, output rdata);
endinterface

// ==== pcl_nv_store.sv ====
`timescale 1ns/10ps
// ==========================================================
// retained word store, no reset so contents survive power cycles
module pcl_nv_store #(
  parameter int DEPTH = 2
) (
  input wire logic clk,
  pcl_nv_if.mem    nv
);

  logic [31:0] mem_q [DEPTH];
  logic [31:0] rd_reg;

  // read first, old word out of a register one cycle later
  always_ff @(posedge clk) begin
    if (nv.we) begin
      mem_q[nv.addr] <= nv.wdata;
    end
    rd_reg <= mem_q[nv.addr];
  end

  assign nv.rdata = rd_reg;

endmodule

// ==== pcl_loader.sv ====
`timescale 1ns/10ps
// Overview of operation
// - switches sampled only once after power-up
// - hardware mode address is prefix plus switches
// - node address 00 and FF are invalid
// - latched node address kept for session
// - mode switch picks switches or software values
// - software mode ignores node address switches
// - software mode ignores hold/clear switch
// - software mode always clears outputs on error
// - comm error holds or clears all outputs
// - hold/clear switch off clears on error
// - nothing written gives default address
// - address written in software mode applies after next software start
// - address written in software mode retained across power-off
// - hardware start overwrites store with default
// - written ip is class F5 instance 1 attribute 5
module pcl_loader #(
  parameter int OUT_W  = 16,
  parameter int ADDR_W = 8
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]        s_axi_awprot,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]        s_axi_arprot,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic [7:0]        node_address_switch,
  input  wire logic              output_hold_clear_switch,
  input  wire logic              setting_mode_switch,
  input  wire logic              bus_line_error,
  input  wire logic              comm_timeout,
  output logic [OUT_W-1:0]       valve_out,
  output logic                   net_enable,
  output logic                   cfg_error,
  output logic                   irq
);

  // ==========================================================
  // retained store
  pcl_nv_if nv_bus ();
  pcl_nv_store #(.DEPTH (2)) u_store (.clk (aclk), .nv (nv_bus.mem));

  // ==========================================================
  // state
  pcl_pkg::pcl_state_t       state_reg, state_next;
  logic                      sw_mode_reg, sw_mode_next, hold_reg, hold_next;
  logic                      err_reg, err_next, loaded_reg, loaded_next;
  logic                      join_reg, join_next, irq_reg, irq_next;
  logic                      aw_have_reg, aw_have_next;
  logic                      w_have_reg, w_have_next;
  logic                      bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
  logic                      arready_reg, arready_next;
  logic                      awready_reg, wready_reg;
  logic [7:0]                na_reg, na_next;
  logic [31:0]               stored_ip_reg, stored_ip_next;
  logic [31:0]               act_ip_reg, act_ip_next;
  logic [31:0]               pend_ip_reg, pend_ip_next;
  logic [31:0]               w_data_reg, w_data_next, rdata_reg, rdata_next;
  logic [OUT_W-1:0]          out_data_reg, out_data_next;
  logic [OUT_W-1:0]          valve_reg, valve_next;
  logic [pcl_pkg::IRQ_W-1:0] ist_reg, ist_next, ien_reg, ien_next;
  logic [ADDR_W-1:0]         aw_addr_reg, aw_addr_next;
  logic [3:0]                w_strb_reg, w_strb_next;
  logic [1:0]                bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic                      nv_we, nv_addr;
  logic [31:0]               nv_wdata;
  // merge byte lanes of a write into an old value
  function automatic logic [31:0] merge(input logic [31:0] old, val,
                                        input logic [3:0]  strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = val[8*i +: 8];
      end
    end
    return res;
  endfunction

  // ==========================================================
  // next-state logic: loader sequence, registers, bus slave
  always_comb begin
    logic        do_wr;
    logic        comm_err;
    logic [7:0]  wofs;
    logic [31:0] status;
    logic [pcl_pkg::IRQ_W-1:0] ev;
    logic [pcl_pkg::IRQ_W-1:0] clr;
    do_wr    = 1'b0;
    comm_err = bus_line_error | comm_timeout;
    wofs     = 8'(aw_addr_reg);
    ev       = '0;
    clr      = '0;
    status   = '0;
    state_next = state_reg;
    rresp_next = rresp_reg;
    {sw_mode_next, hold_next, na_next, err_next, loaded_next} =
      {sw_mode_reg, hold_reg, na_reg, err_reg, loaded_reg};
    {stored_ip_next, act_ip_next, pend_ip_next, out_data_next, ien_next} =
      {stored_ip_reg, act_ip_reg, pend_ip_reg, out_data_reg, ien_reg};
    {aw_have_next, aw_addr_next, w_have_next, w_data_next, w_strb_next} =
      {aw_have_reg, aw_addr_reg, w_have_reg, w_data_reg, w_strb_reg};
    {bvalid_next, bresp_next, arready_next, rvalid_next, rdata_next} =
      {bvalid_reg, bresp_reg, arready_reg, rvalid_reg, rdata_reg};
    nv_we    = 1'b0;
    nv_addr  = pcl_pkg::NV_IP_IDX;
    nv_wdata = pcl_pkg::DEFAULT_IP;

    // power-up loader; switches are never looked at after sampling
    case (state_reg)
      pcl_pkg::PCL_SAMPLE: begin
        sw_mode_next = setting_mode_switch;
        if (setting_mode_switch) begin
          hold_next = 1'b0;
          na_next   = 8'h00;
          err_next  = 1'b0;
        end else begin
          hold_next = output_hold_clear_switch;
          na_next   = node_address_switch;
          err_next  = (node_address_switch < pcl_pkg::NA_MIN) ||
                      (node_address_switch > pcl_pkg::NA_MAX);
        end
        nv_addr    = pcl_pkg::NV_IP_IDX;
        state_next = pcl_pkg::PCL_RD_IP;
      end
      pcl_pkg::PCL_RD_IP: begin
        stored_ip_next = nv_bus.rdata;
        nv_addr        = pcl_pkg::NV_FLAG_IDX;
        state_next     = pcl_pkg::PCL_RD_FLAG;
      end
      pcl_pkg::PCL_RD_FLAG: begin
        if (sw_mode_reg) begin
          // written address takes effect only at this start
          if (nv_bus.rdata == pcl_pkg::NV_MAGIC) begin
            act_ip_next = stored_ip_reg;
          end else begin
            act_ip_next = pcl_pkg::DEFAULT_IP;
          end
          pend_ip_next = act_ip_next;
          loaded_next  = 1'b1;
          ev[pcl_pkg::IRQ_LOADED] = 1'b1;
          state_next   = pcl_pkg::PCL_RUN;
        end else begin
          act_ip_next  = {pcl_pkg::IP_PREFIX, na_reg};
          pend_ip_next = pcl_pkg::DEFAULT_IP;
          state_next   = pcl_pkg::PCL_WR_IP;
        end
      end
      pcl_pkg::PCL_WR_IP: begin
        nv_we      = 1'b1;
        nv_addr    = pcl_pkg::NV_IP_IDX;
        nv_wdata   = pcl_pkg::DEFAULT_IP;
        state_next = pcl_pkg::PCL_WR_FLAG;
      end
      pcl_pkg::PCL_WR_FLAG: begin
        nv_we       = 1'b1;
        nv_addr     = pcl_pkg::NV_FLAG_IDX;
        nv_wdata    = pcl_pkg::NV_CLEARED;
        loaded_next = 1'b1;
        ev[pcl_pkg::IRQ_LOADED]  = 1'b1;
        ev[pcl_pkg::IRQ_CFG_ERR] = err_reg;
        state_next  = pcl_pkg::PCL_RUN;
      end
      pcl_pkg::PCL_SW_IP: begin
        nv_we      = 1'b1;
        nv_addr    = pcl_pkg::NV_IP_IDX;
        nv_wdata   = pend_ip_reg;
        state_next = pcl_pkg::PCL_SW_FLAG;
      end
      pcl_pkg::PCL_SW_FLAG: begin
        nv_we      = 1'b1;
        nv_addr    = pcl_pkg::NV_FLAG_IDX;
        nv_wdata   = pcl_pkg::NV_MAGIC;
        ev[pcl_pkg::IRQ_IP_WR] = 1'b1;
        state_next = pcl_pkg::PCL_RUN;
      end
      pcl_pkg::PCL_RUN: begin
        state_next = pcl_pkg::PCL_RUN;
      end
      default: begin
        state_next = pcl_pkg::PCL_SAMPLE;
      end
    endcase

    // write channels: address and data taken in either order
    if (s_axi_awvalid && s_axi_awready) begin
      aw_have_next = 1'b1;
      aw_addr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_have_next = 1'b1;
      w_data_next = s_axi_wdata;
      w_strb_next = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      bvalid_next = 1'b0;
    end

    // writes wait for the loader; store updates must not race it
    if (aw_have_reg && w_have_reg && !bvalid_reg &&
        state_reg == pcl_pkg::PCL_RUN) begin
      do_wr        = 1'b1;
      aw_have_next = 1'b0;
      w_have_next  = 1'b0;
      bvalid_next  = 1'b1;
      bresp_next   = pcl_pkg::RESP_OKAY;
    end

    // register write decode
    if (do_wr) begin
      case (wofs)
        pcl_pkg::OFS_PEND_IP: begin
          // stored now; saved in software mode only, used as address only after restart
          pend_ip_next = merge(pend_ip_reg, w_data_reg, w_strb_reg);
          if (sw_mode_reg) begin
            state_next = pcl_pkg::PCL_SW_IP;
          end
        end
        pcl_pkg::OFS_OUT: begin
          out_data_next = OUT_W'(merge(32'(out_data_reg), w_data_reg,
                                       w_strb_reg));
        end
        pcl_pkg::OFS_IRQ_CLR: begin
          clr = w_data_reg[pcl_pkg::IRQ_W-1:0];
        end
        pcl_pkg::OFS_IRQ_EN: begin
          ien_next = w_data_reg[pcl_pkg::IRQ_W-1:0];
        end
        pcl_pkg::OFS_STATUS, pcl_pkg::OFS_ACT_IP,
        pcl_pkg::OFS_IRQ_ST, pcl_pkg::OFS_PATH: begin
          bresp_next = pcl_pkg::RESP_OKAY;               // read-only
        end
        default: begin
          bresp_next = pcl_pkg::RESP_SLVERR;
        end
      endcase
    end

    // status word
    status[pcl_pkg::ST_SW_MODE] = sw_mode_reg;
    status[pcl_pkg::ST_HOLD]    = hold_reg;
    status[pcl_pkg::ST_CFG_ERR] = err_reg;
    status[pcl_pkg::ST_LOADED]  = loaded_reg;
    status[pcl_pkg::ST_JOINED]  = join_reg;
    status[pcl_pkg::ST_NA_LSB +: 8] = na_reg;

    // read channel, one outstanding read
    if (s_axi_rvalid && s_axi_rready) begin
      rvalid_next  = 1'b0;
      arready_next = 1'b1;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      arready_next = 1'b0;
      rvalid_next  = 1'b1;
      rresp_next   = pcl_pkg::RESP_OKAY;
      case (8'(s_axi_araddr))
        pcl_pkg::OFS_STATUS:  rdata_next = status;
        pcl_pkg::OFS_ACT_IP:  rdata_next = act_ip_reg;
        pcl_pkg::OFS_PEND_IP: rdata_next = pend_ip_reg;
        pcl_pkg::OFS_OUT:     rdata_next = 32'(out_data_reg);
        pcl_pkg::OFS_IRQ_ST:  rdata_next = 32'(ist_reg);
        pcl_pkg::OFS_IRQ_CLR: rdata_next = 32'h0000_0000;
        pcl_pkg::OFS_IRQ_EN:  rdata_next = 32'(ien_reg);
        pcl_pkg::OFS_PATH: begin
          rdata_next = {8'h00, pcl_pkg::TCPIP_CLASS,
                        pcl_pkg::TCPIP_INST, pcl_pkg::TCPIP_ATTR};
        end
        default: begin
          rdata_next = 32'h0000_0000;
          rresp_next = pcl_pkg::RESP_SLVERR;
        end
      endcase
    end

    // interrupts: a new event beats a clear in the same cycle
    ev[pcl_pkg::IRQ_COMM] = comm_err && join_reg;
    ist_next = (ist_reg & ~clr) | ev;
    irq_next = |(ist_next & ien_next);

    // joining is blocked by a bad node address
    join_next = loaded_next && !err_next;

    // valve outputs on comm error: hold last or clear all
    if (!join_reg) begin
      valve_next = '0;
    end else if (comm_err) begin
      valve_next = hold_reg ? valve_reg : '0;
    end else begin
      valve_next = out_data_reg;
    end
  end
  assign nv_bus.we    = nv_we;
  assign nv_bus.addr  = nv_addr;
  assign nv_bus.wdata = nv_wdata;

  // ==========================================================
  // registers; zero-reset state grouped to keep the list short
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= pcl_pkg::PCL_SAMPLE;
      {sw_mode_reg, hold_reg, na_reg, err_reg, loaded_reg} <= '0;
      {stored_ip_reg, act_ip_reg, pend_ip_reg, out_data_reg} <= '0;
      {valve_reg, join_reg, ist_reg, ien_reg, irq_reg} <= '0;
      {aw_have_reg, aw_addr_reg, w_have_reg, w_data_reg} <= '0;
      {w_strb_reg, bvalid_reg, rvalid_reg, rdata_reg} <= '0;
      {awready_reg, wready_reg} <= 2'b00;
      bresp_reg   <= pcl_pkg::RESP_OKAY;
      rresp_reg   <= pcl_pkg::RESP_OKAY;
      arready_reg <= 1'b1;                 // reads accepted from reset
    end else begin
      state_reg <= state_next;
      {sw_mode_reg, hold_reg, na_reg, err_reg, loaded_reg} <=
        {sw_mode_next, hold_next, na_next, err_next, loaded_next};
      {stored_ip_reg, act_ip_reg, pend_ip_reg, out_data_reg} <=
        {stored_ip_next, act_ip_next, pend_ip_next, out_data_next};
      {valve_reg, join_reg, ist_reg, ien_reg, irq_reg} <=
        {valve_next, join_next, ist_next, ien_next, irq_next};
      {aw_have_reg, aw_addr_reg, w_have_reg, w_data_reg} <=
        {aw_have_next, aw_addr_next, w_have_next, w_data_next};
      {w_strb_reg, bvalid_reg, bresp_reg, arready_reg} <=
        {w_strb_next, bvalid_next, bresp_next, arready_next};
      {rvalid_reg, rdata_reg, rresp_reg} <=
        {rvalid_next, rdata_next, rresp_next};
      // a channel is ready while its holding slot is empty
      awready_reg <= !aw_have_next;
      wready_reg  <= !w_have_next;
    end
  end

  // ==========================================================
  // outputs, all from flip-flops

  assign s_axi_awready = awready_reg;
  assign s_axi_wready  = wready_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;
  assign valve_out     = valve_reg;
  assign net_enable    = join_reg;
  assign cfg_error     = err_reg;
  assign irq           = irq_reg;

endmodule

// ==== pcl_loader_properties.sv ====
`timescale 1ns/10ps
// ==========================================================
// port checker for the power-up loader
module pcl_loader_chk #(
  parameter int OUT_W  = 16,
  parameter int ADDR_W = 8
) (
  input wire logic             aclk,
  input wire logic             aresetn,
  input wire logic             s_axi_arvalid,
  input wire logic             s_axi_arready,
  input wire logic             s_axi_rvalid,
  input wire logic             s_axi_rready,
  input wire logic [31:0]      s_axi_rdata,
  input wire logic [7:0]       node_address_switch,
  input wire logic             output_hold_clear_switch,
  input wire logic             setting_mode_switch,
  input wire logic             bus_line_error,
  input wire logic             comm_timeout,
  input wire logic [OUT_W-1:0] valve_out,
  input wire logic             net_enable,
  input wire logic             cfg_error
);
  logic [3:0] cnt_reg;
  logic       sw_reg;
  logic       hc_reg;
  logic [7:0] na_reg;
  logic       comm_err;
  logic       na_bad;

  // ==========================================================
  // session age and switch snapshot
  // snapshot taken on first edge after release, so later switch
  // moves cannot mislead the checks below
  always_ff @(posedge aclk) begin
    if (!aresetn) cnt_reg <= 4'h0;
    else if (cnt_reg != 4'hf) cnt_reg <= cnt_reg + 4'h1;
    if (aresetn && cnt_reg == 4'h0) begin
      sw_reg <= setting_mode_switch;
      hc_reg <= output_hold_clear_switch;
      na_reg <= node_address_switch;
    end
  end
  // error qualifiers
  assign comm_err = bus_line_error | comm_timeout;
  assign na_bad   = (na_reg == 8'h00) || (na_reg == 8'hff);

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_ar_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_joined_err;
    net_enable && comm_err;
  endsequence

  property p_rd_answer;
    s_ar_take |=> s_axi_rvalid;
  endproperty
  a_rd_answer: assert property (p_rd_answer)
    else $error("read not answered next cycle");
  property p_rd_stand;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rd_stand: assert property (p_rd_stand)
    else $error("read answer dropped early");
  property p_sw_clear;
    s_joined_err and sw_reg |=> valve_out == {OUT_W{1'b0}};
  endproperty
  a_sw_clear: assert property (p_sw_clear)
    else $error("software mode did not clear outputs");
  property p_hw_clear;
    s_joined_err and !sw_reg && !hc_reg |=> valve_out == {OUT_W{1'b0}};
  endproperty
  a_hw_clear: assert property (p_hw_clear)
    else $error("clear mode did not clear outputs");
  property p_hw_hold;
    s_joined_err and !sw_reg && hc_reg |=> $stable(valve_out);
  endproperty
  a_hw_hold: assert property (p_hw_hold)
    else $error("hold mode changed outputs");
  property p_off_zero;
    !net_enable [*2] |-> valve_out == {OUT_W{1'b0}};
  endproperty
  a_off_zero: assert property (p_off_zero)
    else $error("outputs driven while not joined");
  property p_bad_na;
    cnt_reg == 4'h8 && !sw_reg && na_bad |-> cfg_error && !net_enable;
  endproperty
  a_bad_na: assert property (p_bad_na)
    else $error("invalid node address accepted");
  property p_good_na;
    cnt_reg == 4'h8 && !sw_reg && !na_bad |-> net_enable && !cfg_error;
  endproperty
  a_good_na: assert property (p_good_na)
    else $error("valid node address not joined");
  property p_sw_join;
    cnt_reg == 4'h8 && sw_reg |-> net_enable && !cfg_error;
  endproperty
  a_sw_join: assert property (p_sw_join)
    else $error("software mode looked at node switches");
  property p_kept;
    cnt_reg > 4'h8 |-> $stable(net_enable) && $stable(cfg_error);
  endproperty
  a_kept: assert property (p_kept)
    else $error("configuration changed within session");
endmodule

bind pcl_loader pcl_loader_chk #(.OUT_W(OUT_W), .ADDR_W(ADDR_W)) u_chk (.*);

// ==== pcl_switch_model.sv ====
`timescale 1ns/10ps
// ==========================================================
// switch bank and comm error lines; switches are static levels
module pcl_switch_model (
  input wire logic aclk,
  output logic [7:0] node_address_switch,
  output logic       output_hold_clear_switch,
  output logic       setting_mode_switch,
  output logic       bus_line_error,
  output logic       comm_timeout
);
  // switches at rest until the bench sets them
  initial begin
    node_address_switch = 8'h01;
    output_hold_clear_switch = 1'b0;
    setting_mode_switch = 1'b0;
    bus_line_error = 1'b0;
    comm_timeout = 1'b0;
  end
  // moved right after an edge, like a hand on the switch
  task automatic set_sw(input logic [7:0] na, input logic hc, md);
    @(posedge aclk);
    node_address_switch <= na;
    output_hold_clear_switch <= hc;
    setting_mode_switch <= md;
  endtask
  // error lines are levels held until changed
  task automatic set_err(input logic b, t);
    @(posedge aclk);
    bus_line_error <= b;
    comm_timeout <= t;
  endtask
endmodule

// ==== testbench.sv ====
`timescale 1ns/10ps
module testbench;
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0, s_axi_bvalid, s_axi_rvalid;
  logic        s_axi_awready, s_axi_wready, s_axi_arready;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [7:0]  node_address_switch;
  logic        output_hold_clear_switch, setting_mode_switch;
  logic        bus_line_error, comm_timeout, net_enable, cfg_error, irq;
  logic [15:0] valve_out;
  int          n_mismatch = 0, n_checks = 0;

  pcl_loader u_pcl_loader (.*);
  pcl_switch_model u_pcl_switch_model (.*);

  // ==========================================================
  // clock
  always #2 aclk = ~aclk;

  // ==========================================================
  // compare, end of run, bounded waits
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic tmo(input int n);
    if (n >= 300) begin
      n_mismatch++;
      $display("FAIL bus_wait expected answer seen none");
      stop_test();
    end
  endtask

  // ==========================================================
  // bus master; valid held until its own ready edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 300);
    s_axi_bready <= 1'b0;
    tmo(n);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    int n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 300);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    tmo(n);
  endtask
  task automatic rc(input string nm, input logic [7:0] a,
                    input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk(nm, e, d);
  endtask
  // power cycle: store keeps its words, switches set while off
  task automatic pwr(input logic [7:0] na, input logic hc, md);
    u_pcl_switch_model.set_sw(na, hc, md);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (10) @(posedge aclk);
  endtask

  // ==========================================================
  // scenarios
  task automatic t_hw;
    logic [31:0] d;
    logic [1:0]  r;
    pwr(8'h47, 1'b1, 1'b0);
    rc("act_ip", pcl_pkg::OFS_ACT_IP, {pcl_pkg::IP_PREFIX, 8'h47});
    rc("status", pcl_pkg::OFS_STATUS, 32'h0000_471a);
    u_pcl_switch_model.set_sw(8'hff, 1'b0, 1'b1);
    repeat (4) @(posedge aclk);
    rc("act_ip", pcl_pkg::OFS_ACT_IP, {pcl_pkg::IP_PREFIX, 8'h47});
    rc("status", pcl_pkg::OFS_STATUS, 32'h0000_471a);
    chk("cfg_error", 32'h0, cfg_error);
    rc("path", pcl_pkg::OFS_PATH, {8'h00, pcl_pkg::TCPIP_CLASS,
       pcl_pkg::TCPIP_INST, pcl_pkg::TCPIP_ATTR});
    rd(8'h20, d, r);
    chk("unmapped_resp", {30'h0, pcl_pkg::RESP_SLVERR}, r);
    $display("test hw done");
  endtask
  task automatic t_inval;
    logic [7:0] na;
    for (int i = 0; i < 2; i++) begin
      na = i ? 8'hff : 8'h00;
      pwr(na, 1'b0, 1'b0);
      chk("cfg_error", 32'h1, cfg_error);
      chk("net_enable", 32'h0, net_enable);
      rc("act_ip", pcl_pkg::OFS_ACT_IP, {pcl_pkg::IP_PREFIX, na});
    end
    $display("test inval done");
  endtask
  task automatic t_sw;
    pwr(8'h00, 1'b0, 1'b0);
    pwr(8'h00, 1'b1, 1'b1);
    rc("act_ip", pcl_pkg::OFS_ACT_IP, pcl_pkg::DEFAULT_IP);
    chk("cfg_error", 32'h0, cfg_error);
    wr(pcl_pkg::OFS_PEND_IP, 32'h0a11_2201);
    rc("act_ip", pcl_pkg::OFS_ACT_IP, pcl_pkg::DEFAULT_IP);
    pwr(8'h33, 1'b0, 1'b1);
    rc("act_ip", pcl_pkg::OFS_ACT_IP, 32'h0a11_2201);
    pwr(8'h33, 1'b0, 1'b0);
    pwr(8'h33, 1'b0, 1'b1);
    rc("act_ip", pcl_pkg::OFS_ACT_IP, pcl_pkg::DEFAULT_IP);
    $display("test sw done");
  endtask
  task automatic t_valve;
    pwr(8'h05, 1'b1, 1'b0);
    wr(pcl_pkg::OFS_OUT, 32'h0000_5a5a);
    repeat (3) @(posedge aclk);
    chk("valve_out", 32'h0000_5a5a, valve_out);
    u_pcl_switch_model.set_err(1'b1, 1'b0);
    wr(pcl_pkg::OFS_OUT, 32'h0000_1234);
    repeat (3) @(posedge aclk);
    chk("valve_out", 32'h0000_5a5a, valve_out);
    u_pcl_switch_model.set_err(1'b0, 1'b0);
    repeat (3) @(posedge aclk);
    chk("valve_out", 32'h0000_1234, valve_out);
    for (int m = 0; m < 2; m++) begin
      pwr(8'h05, m[0], m[0]);
      wr(pcl_pkg::OFS_OUT, 32'h0000_1234);
      u_pcl_switch_model.set_err(m[0], !m[0]);
      repeat (3) @(posedge aclk);
      chk("valve_out", 32'h0, valve_out);
      u_pcl_switch_model.set_err(1'b0, 1'b0);
    end
    $display("test valve done");
  endtask
  task automatic t_irq;
    wr(pcl_pkg::OFS_IRQ_CLR, 32'h0000_000f);
    wr(pcl_pkg::OFS_IRQ_EN, 32'h0000_0001);
    rc("irq_status", pcl_pkg::OFS_IRQ_ST, 32'h0);
    chk("irq", 32'h0, irq);
    u_pcl_switch_model.set_err(1'b0, 1'b1);
    repeat (3) @(posedge aclk);
    u_pcl_switch_model.set_err(1'b0, 1'b0);
    repeat (3) @(posedge aclk);
    chk("irq", 32'h1, irq);
    rc("irq_status", pcl_pkg::OFS_IRQ_ST, 32'h1);
    wr(pcl_pkg::OFS_IRQ_EN, 32'h0);
    repeat (3) @(posedge aclk);
    chk("irq_masked", 32'h0, irq);
    wr(pcl_pkg::OFS_IRQ_EN, 32'h0000_0001);
    repeat (3) @(posedge aclk);
    chk("irq", 32'h1, irq);
    wr(pcl_pkg::OFS_IRQ_CLR, 32'h0000_0001);
    repeat (3) @(posedge aclk);
    chk("irq_cleared", 32'h0, irq);
    $display("test irq done");
  endtask

  // ==========================================================
  // main sequence
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_hw;
    t_inval;
    t_sw;
    t_valve;
    t_irq;
    stop_test();
  end
endmodule
